// ### qirq_top.sv
// Interrupt pin steering and ready/status outputs of a four-channel UART.
`timescale 1ns/1ps
`default_nettype none
`include "qirq_regs.svh"

// Behaviour
// - Strobe mode uses channel D select as active-low enable; other mode ignores it.
// - Read/write-line mode: channel A pin is shared active-low open-drain interrupt.
// - Read/write-line mode: channel B, C, D interrupt outputs held at logic zero.
// - Strobe mode: override input high enables all interrupt outputs regardless of bit.
// - Each channel drives active-low transmitter-ready from its transmit FIFO state.
// - With DMA enabled, transmitter-ready output becomes transmit DMA request.
// - Each channel drives active-low receiver-ready from its receive FIFO state.
// - With DMA enabled, receiver-ready output becomes receive DMA request.
// - Combined transmitter-ready is the wired-OR of the four channel signals.
// - Combined receiver-ready is the wired-OR of the four channel signals.
// - Status select low puts the FIFO status byte on the data bus.
// - Status byte: inverted tx-ready A-D on bits 0-3, rx-ready A-D on 4-7.
// - Transmit DMA request holds high until terminal count pulses or FIFO passes trigger.
// - Receive DMA request holds high until terminal count pulses or FIFO empties.
module qirq_top
    import qirq_pkg::*;
#(
    parameter int NUM_CHAN = `QIRQ_NUM_CHAN
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Bus-style and select pins
    input wire logic bus_strobe_select,
    input wire logic channel_d_select_n,
    input wire logic irq_output_override,
    input wire logic fifo_status_select_n,
    // Channel interrupt requests and mode bits
    input wire logic [NUM_CHAN-1:0] chan_irq_pending,
    input wire logic [NUM_CHAN-1:0] irq_output_enable_bit,
    input wire logic [NUM_CHAN-1:0] tx_dma_enable,
    input wire logic [NUM_CHAN-1:0] rx_dma_enable,
    // FIFO conditions from the channel logic
    input wire logic [NUM_CHAN-1:0] tx_space_ready,
    input wire logic [NUM_CHAN-1:0] tx_above_trigger,
    input wire logic [NUM_CHAN-1:0] rx_data_ready,
    input wire logic [NUM_CHAN-1:0] rx_fifo_empty,
    input wire logic dma_terminal_count,
    // Interrupt pins
    output logic channel_a_irq,
    output logic channel_a_irq_oe,
    output logic channel_b_irq,
    output logic channel_b_irq_oe,
    output logic channel_c_irq,
    output logic channel_c_irq_oe,
    output logic channel_d_irq,
    output logic channel_d_irq_oe,
    output logic channel_d_enabled,
    // Ready and DMA pins
    output logic [NUM_CHAN-1:0] chan_tx_ready_n,
    output logic [NUM_CHAN-1:0] chan_rx_ready_n,
    output logic combined_tx_ready_n,
    output logic combined_rx_ready_n,
    // Status byte onto the data bus
    output logic [`QIRQ_STATUS_WIDTH-1:0] data_out,
    output logic data_out_oe
);

    // ============================================================
    // Synchronised pins

    localparam int PIN_W = 4;
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_sync;
    logic term_sync;

    // Pull-ups and pull-downs set the idle reset values.
    assign pins_raw = {bus_strobe_select, channel_d_select_n, irq_output_override, fifo_status_select_n};

    qirq_sync #(
        .WIDTH(PIN_W),
        .RESET_VALUE(4'hD)
    ) u_pin_sync (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .async_in(pins_raw),
        .sync_out(pins_sync)
    );

    qirq_sync #(
        .WIDTH(1),
        .RESET_VALUE(1'b0)
    ) u_term_sync (
        .clk(clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .async_in(dma_terminal_count),
        .sync_out(term_sync)
    );

    qirq_bus_e bus_style;
    logic chd_sel_n_s;
    logic override_s;
    logic fsel_n_s;

    always_comb begin
        bus_style = pins_sync[3] ? QIRQ_BUS_STROBE : QIRQ_BUS_RW_LINE;
        chd_sel_n_s = pins_sync[2];
        override_s = pins_sync[1];
        fsel_n_s = pins_sync[0];
    end

    // ============================================================
    // Registered state

    typedef struct packed {
        logic [NUM_CHAN-1:0] irq_lvl;
        logic [NUM_CHAN-1:0] irq_oe;
        logic chd_en;
        logic [NUM_CHAN-1:0] tx_rdy_n;
        logic [NUM_CHAN-1:0] rx_rdy_n;
        logic tx_all_n;
        logic rx_all_n;
        logic [`QIRQ_STATUS_WIDTH-1:0] status;
        logic status_oe;
    } qirq_top_s;

    qirq_top_s state;
    qirq_top_s next_state;

    logic [NUM_CHAN-1:0] tx_dma_req;
    logic [NUM_CHAN-1:0] rx_dma_req;

    // ============================================================
    // Per-channel DMA request latches

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
            qirq_dma_req u_tx_dma (
                .clk(clk),
                .resetn(resetn),
                .clk_en(clk_en),
                .dma_enable(tx_dma_enable[gi]),
                .request_cond(tx_space_ready[gi]),
                .stop_cond(tx_above_trigger[gi]),
                .terminal_count(term_sync),
                .dma_request(tx_dma_req[gi])
            );
            qirq_dma_req u_rx_dma (
                .clk(clk),
                .resetn(resetn),
                .clk_en(clk_en),
                .dma_enable(rx_dma_enable[gi]),
                .request_cond(rx_data_ready[gi]),
                .stop_cond(rx_fifo_empty[gi]),
                .terminal_count(term_sync),
                .dma_request(rx_dma_req[gi])
            );
        end
    endgenerate

    // ============================================================
    // Next-state logic

    logic [NUM_CHAN-1:0] tx_n;
    logic [NUM_CHAN-1:0] rx_n;

    always_comb begin
        next_state = state;
        tx_n = '0;
        rx_n = '0;
        if (clk_en) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                // DMA mode drives the pin high as an active-high request.
                tx_n[i] = tx_dma_enable[i] ? tx_dma_req[i] : !tx_space_ready[i];
                rx_n[i] = rx_dma_enable[i] ? rx_dma_req[i] : !rx_data_ready[i];
            end
            next_state.tx_rdy_n = tx_n;
            next_state.rx_rdy_n = rx_n;
            // Active-low wired-OR: low when any channel is ready.
            next_state.tx_all_n = &tx_n;
            next_state.rx_all_n = &rx_n;
            for (int i = 0; i < NUM_CHAN; i++) begin
                next_state.status[`QIRQ_STATUS_TX_LSB + i] = !tx_n[i];
                next_state.status[`QIRQ_STATUS_RX_LSB + i] = rx_n[i];
            end
            next_state.status_oe = !fsel_n_s;

            if (bus_style == QIRQ_BUS_STROBE) begin
                next_state.chd_en = !chd_sel_n_s;
                for (int i = 0; i < NUM_CHAN; i++) begin
                    next_state.irq_lvl[i] = chan_irq_pending[i];
                    next_state.irq_oe[i] = irq_output_enable_bit[i] || override_s;
                end
            end else begin
                // Override is assumed low here by the board.
                next_state.chd_en = 1'b0;
                next_state.irq_lvl = '0;
                next_state.irq_oe = {{(NUM_CHAN-1){1'b1}}, 1'b0};
                // Open drain: only pull low while any channel requests.
                next_state.irq_oe[0] = |chan_irq_pending;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
            state.tx_rdy_n <= '1;
            state.rx_rdy_n <= '1;
            state.tx_all_n <= 1'b1;
            state.rx_all_n <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ============================================================
    // Outputs

    assign channel_a_irq = state.irq_lvl[0];
    assign channel_a_irq_oe = state.irq_oe[0];
    assign channel_b_irq = state.irq_lvl[1];
    assign channel_b_irq_oe = state.irq_oe[1];
    assign channel_c_irq = state.irq_lvl[2];
    assign channel_c_irq_oe = state.irq_oe[2];
    assign channel_d_irq = state.irq_lvl[3];
    assign channel_d_irq_oe = state.irq_oe[3];
    assign channel_d_enabled = state.chd_en;
    assign chan_tx_ready_n = state.tx_rdy_n;
    assign chan_rx_ready_n = state.rx_rdy_n;
    assign combined_tx_ready_n = state.tx_all_n;
    assign combined_rx_ready_n = state.rx_all_n;
    assign data_out = state.status;
    assign data_out_oe = state.status_oe;

endmodule // qirq_top

`default_nettype wire

// ### qirq_regs.svh
// Constants for the quad UART interrupt and ready-status pin logic.
`ifndef QIRQ_REGS_SVH
`define QIRQ_REGS_SVH

// ============================================================
// Geometry
`define QIRQ_NUM_CHAN 4
`define QIRQ_STATUS_WIDTH 8

// ============================================================
// Status byte field positions
`define QIRQ_STATUS_TX_LSB 0
`define QIRQ_STATUS_RX_LSB 4

// ============================================================
// Mode register bit positions (per channel)
`define QIRQ_MODE_IRQ_EN_BIT 3
`define QIRQ_DMA_MODE_TX_BIT 2
`define QIRQ_DMA_MODE_RX_BIT 3

// ============================================================
// Reset values
`define QIRQ_IRQ_EN_RESET 4'h0
`define QIRQ_DMA_EN_RESET 4'h0

`endif

// ### qirq_pkg.sv
// Types for the quad UART interrupt and ready-status pin logic.
package qirq_pkg;

    typedef enum logic {
        QIRQ_BUS_RW_LINE,
        QIRQ_BUS_STROBE
    } qirq_bus_e;

    typedef logic [3:0] qirq_chan_t;

endpackage

// ### qirq_sync.sv
// Two-flop synchroniser bank for asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none

module qirq_sync
    import qirq_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } qirq_sync_s;

    qirq_sync_s state;
    qirq_sync_s next_state;

    always_comb begin
        next_state = state;
        if (clk_en) begin
            next_state.stage1 = async_in;
            next_state.stage2 = state.stage1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= {RESET_VALUE, RESET_VALUE};
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stage2;

endmodule // qirq_sync

`default_nettype wire

// ### qirq_dma_req.sv
// One channel's DMA request latch, ended by terminal count or FIFO level.
`timescale 1ns/1ps
`default_nettype none

module qirq_dma_req
    import qirq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Control
    input wire logic dma_enable,
    input wire logic request_cond,
    input wire logic stop_cond,
    input wire logic terminal_count,
    // Result
    output logic dma_request
);

    typedef struct packed {
        logic req;
        logic term_prev;
    } qirq_dma_s;

    qirq_dma_s state;
    qirq_dma_s next_state;
    logic term_pulse;

    // The request is dropped on the terminal count rising edge and only
    // re-armed after the terminal count has fallen again, so one count ends one burst.
    always_comb begin
        next_state = state;
        term_pulse = terminal_count && !state.term_prev;
        if (clk_en) begin
            next_state.term_prev = terminal_count;
            if (!dma_enable) begin
                next_state.req = 1'b0;
            end else if (term_pulse || stop_cond) begin
                next_state.req = 1'b0;
            end else if (request_cond && !state.req && !state.term_prev) begin
                next_state.req = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign dma_request = state.req;

endmodule // qirq_dma_req

`default_nettype wire

// ### qirq_top_asserts.sv
// Concurrent checks on the interrupt, ready and status pins of qirq_top.
`timescale 1ns/1ps
`default_nettype none
`include "qirq_regs.svh"
module qirq_top_asserts
    import qirq_pkg::*;
#(
    parameter int NUM_CHAN = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pins and levels into the block
    input wire logic bus_strobe_select,
    input wire logic channel_d_select_n,
    input wire logic irq_output_override,
    input wire logic fifo_status_select_n,
    input wire logic [NUM_CHAN-1:0] chan_irq_pending,
    input wire logic [NUM_CHAN-1:0] irq_output_enable_bit,
    input wire logic [NUM_CHAN-1:0] tx_dma_enable,
    input wire logic [NUM_CHAN-1:0] rx_dma_enable,
    input wire logic [NUM_CHAN-1:0] tx_space_ready,
    input wire logic [NUM_CHAN-1:0] rx_data_ready,
    // Pins out of the block
    input wire logic channel_a_irq,
    input wire logic channel_a_irq_oe,
    input wire logic channel_b_irq,
    input wire logic channel_b_irq_oe,
    input wire logic channel_c_irq_oe,
    input wire logic channel_d_irq_oe,
    input wire logic channel_d_enabled,
    input wire logic [NUM_CHAN-1:0] chan_tx_ready_n,
    input wire logic [NUM_CHAN-1:0] chan_rx_ready_n,
    input wire logic combined_tx_ready_n,
    input wire logic combined_rx_ready_n,
    input wire logic [`QIRQ_STATUS_WIDTH-1:0] data_out,
    input wire logic data_out_oe
);
    // ============================================================
    // Pin relations
    // Pin inputs pass a two-flop synchroniser, so mode checks wait for four steady samples.
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_tx_ready_level: assert property (tx_dma_enable == '0 && $past(tx_dma_enable) == '0
        |=> chan_tx_ready_n == ~$past(tx_space_ready)) else $error("tx ready level wrong");
    a_rx_ready_level: assert property (rx_dma_enable == '0 && $past(rx_dma_enable) == '0
        |=> chan_rx_ready_n == ~$past(rx_data_ready)) else $error("rx ready level wrong");
    a_comb_tx_ready: assert property (combined_tx_ready_n == &chan_tx_ready_n)
        else $error("combined tx ready wrong");
    a_comb_rx_ready: assert property (combined_rx_ready_n == &chan_rx_ready_n)
        else $error("combined rx ready wrong");
    a_status_byte: assert property (data_out_oe |-> data_out == {chan_rx_ready_n, ~chan_tx_ready_n})
        else $error("status byte wrong");
    a_status_drive: assert property ($stable(fifo_status_select_n) [*4]
        |-> data_out_oe == !fifo_status_select_n) else $error("status drive wrong");
    a_chan_d_enable: assert property ($stable({bus_strobe_select, channel_d_select_n}) [*4]
        |-> channel_d_enabled == (bus_strobe_select && !channel_d_select_n)) else $error("chan d enable wrong");
    a_rw_shared_irq: assert property ((!bus_strobe_select) [*4]
        |-> !channel_a_irq && channel_a_irq_oe == $past(|chan_irq_pending)) else $error("shared irq wrong");
    a_rw_unused_irq: assert property ((!bus_strobe_select) [*4]
        |-> !channel_b_irq && channel_b_irq_oe && channel_c_irq_oe && channel_d_irq_oe) else $error("unused irq");
    a_strobe_irq_oe: assert property ((bus_strobe_select && !irq_output_override) [*4]
        |-> channel_b_irq_oe == $past(irq_output_enable_bit[1]) && channel_b_irq == $past(chan_irq_pending[1]))
        else $error("strobe irq wrong");
    a_override_on: assert property ((bus_strobe_select && irq_output_override) [*4]
        |-> {channel_d_irq_oe, channel_c_irq_oe, channel_b_irq_oe, channel_a_irq_oe} == 4'hF)
        else $error("override not driving");
endmodule // qirq_top_asserts
`default_nettype wire

// ### qirq_host_model.sv
// Host-side model that drives the strap, select and terminal count pins.
`timescale 1ns/1ps
`default_nettype none
module qirq_host_model (
    // Clock
    input wire logic clk,
    // Pins toward the device
    output logic bus_strobe_select,
    output logic channel_d_select_n,
    output logic irq_output_override,
    output logic fifo_status_select_n,
    output logic dma_terminal_count
);
    // ============================================================
    // Pin driving
    initial begin
        bus_strobe_select = 1'b1;
        channel_d_select_n = 1'b1;
        irq_output_override = 1'b0;
        fifo_status_select_n = 1'b1;
        dma_terminal_count = 1'b0;
    end
    // The bus style is a strap; the override is never raised with the read/write-line bus.
    task automatic set_pins(input logic strobe, input logic ovr, input logic chd_sel_n, input logic fsel_n);
        @(negedge clk);
        bus_strobe_select = strobe;
        irq_output_override = ovr & strobe;
        channel_d_select_n = chd_sel_n;
        fifo_status_select_n = fsel_n;
    endtask
    // Two cycles wide, so the synchroniser cannot miss the pulse.
    task automatic pulse_term();
        @(negedge clk);
        dma_terminal_count = 1'b1;
        repeat (2) @(negedge clk);
        dma_terminal_count = 1'b0;
    endtask
endmodule // qirq_host_model
`default_nettype wire

// ### test_quad_uart_irq_ready_status.sv
// Self-checking bench for the quad UART interrupt and ready pin logic.
`timescale 1ns/1ps
`default_nettype none
module test_quad_uart_irq_ready_status;
    import qirq_pkg::*;
    // ============================================================
    // Stimulus and observed pins
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic strobe, chd_sel_n, ovr, fsel_n, term;
    logic [3:0] pend = '0, irq_en = '0, txd = '0, rxd = '0, txr = '0, txt = '0, rxr = '0, rxe = '0;
    logic ia, ia_oe, ib, ib_oe, ic, ic_oe, id, id_oe, d_en, ctx, crx, dout_oe;
    logic [3:0] txn, rxn;
    logic [7:0] dout;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    always #20 clk = ~clk;
    qirq_host_model host (.clk(clk), .bus_strobe_select(strobe), .channel_d_select_n(chd_sel_n),
        .irq_output_override(ovr), .fifo_status_select_n(fsel_n), .dma_terminal_count(term));
    qirq_top uut (.clk(clk), .resetn(resetn), .clk_en(1'b1), .bus_strobe_select(strobe),
        .channel_d_select_n(chd_sel_n), .irq_output_override(ovr), .fifo_status_select_n(fsel_n),
        .chan_irq_pending(pend), .irq_output_enable_bit(irq_en), .tx_dma_enable(txd), .rx_dma_enable(rxd),
        .tx_space_ready(txr), .tx_above_trigger(txt), .rx_data_ready(rxr), .rx_fifo_empty(rxe),
        .dma_terminal_count(term), .channel_a_irq(ia), .channel_a_irq_oe(ia_oe), .channel_b_irq(ib),
        .channel_b_irq_oe(ib_oe), .channel_c_irq(ic), .channel_c_irq_oe(ic_oe), .channel_d_irq(id),
        .channel_d_irq_oe(id_oe), .channel_d_enabled(d_en), .chan_tx_ready_n(txn), .chan_rx_ready_n(rxn),
        .combined_tx_ready_n(ctx), .combined_rx_ready_n(crx), .data_out(dout), .data_out_oe(dout_oe));
    // ============================================================
    // Shared tasks
    task automatic results();
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            results();
        end
    end
    // ============================================================
    // Scenarios
    task automatic t_ready();
        host.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            txr = 4'(i * 5);
            rxr = 4'(i * 3);
            cyc(4);
            chk({4'h0, txn}, {4'h0, ~txr}, "tx ready pins");
            chk({4'h0, rxn}, {4'h0, ~rxr}, "rx ready pins");
            chk(8'({ctx, crx}), 8'({&(~txr), &(~rxr)}), "combined ready");
            chk({dout_oe, 7'h0}, 8'h80, "status drive");
            chk(dout, {~rxr, txr}, "status byte");
        end
        host.set_pins(1'b1, 1'b0, 1'b1, 1'b1);
        cyc(4);
        chk(8'(dout_oe), 8'h00, "status released");
    endtask
    task automatic t_strobe_irq();
        pend = 4'hA;
        irq_en = 4'h6;
        host.set_pins(1'b1, 1'b0, 1'b0, 1'b1);
        cyc(4);
        chk(8'({id_oe, ic_oe, ib_oe, ia_oe}), 8'h06, "strobe irq enables");
        chk(8'({id, ic, ib, ia}), 8'h0A, "strobe irq levels");
        chk(8'(d_en), 8'h01, "chan d selected");
        host.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
        cyc(4);
        chk(8'({id_oe, ic_oe, ib_oe, ia_oe}), 8'h0F, "override enables");
        chk(8'(d_en), 8'h00, "chan d deselected");
    endtask
    task automatic t_rw_irq();
        pend = 4'h0;
        host.set_pins(1'b0, 1'b0, 1'b0, 1'b1);
        cyc(4);
        chk(8'({id_oe, ic_oe, ib_oe, ia_oe}), 8'h0E, "rw idle drives");
        chk(8'({id, ic, ib, ia}), 8'h00, "rw idle levels");
        chk(8'(d_en), 8'h00, "chan d select ignored");
        pend = 4'h4;
        cyc(2);
        chk(8'({id_oe, ic_oe, ib_oe, ia_oe}), 8'h0F, "shared irq pulls low");
        chk(8'({id, ic, ib, ia}), 8'h00, "shared irq level");
        pend = 4'h0;
    endtask
    task automatic t_dma();
        host.set_pins(1'b1, 1'b0, 1'b1, 1'b1);
        txr = 4'h0;
        rxr = 4'h0;
        txd = 4'h1;
        rxd = 4'h2;
        cyc(3);
        chk(8'({rxn[1], txn[0]}), 8'h00, "no dma request");
        txr = 4'h1;
        rxr = 4'h2;
        cyc(3);
        chk(8'({rxn[1], txn[0]}), 8'h03, "dma requests raised");
        txr = 4'h0;
        rxr = 4'h0;
        cyc(3);
        chk(8'({rxn[1], txn[0]}), 8'h03, "dma requests held");
        host.pulse_term();
        cyc(4);
        chk(8'({rxn[1], txn[0]}), 8'h00, "terminal count ends");
        txr = 4'h1;
        rxr = 4'h2;
        cyc(3);
        chk(8'({rxn[1], txn[0]}), 8'h03, "dma requests re-armed");
        txt = 4'h1;
        rxe = 4'h2;
        cyc(3);
        chk(8'({rxn[1], txn[0]}), 8'h00, "fifo level ends");
    endtask
    // A second reset in mid-run: pins go to their idle levels at once and follow the inputs after.
    task automatic t_reset();
        txd = 4'h0;
        rxd = 4'h0;
        resetn = 1'b0;
        cyc(1);
        chk({txn, rxn}, 8'hFF, "reset ready pins");
        chk({ctx, crx, dout_oe, d_en, ia_oe, ib_oe, ic_oe, id_oe}, 8'hC0, "reset pin drives");
        chk(dout, 8'h00, "reset status byte");
        resetn = 1'b1;
        cyc(2);
        chk({4'h0, txn}, {4'h0, ~txr}, "ready after reset");
    endtask
    initial begin
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        cyc(1);
        t_ready();
        t_strobe_irq();
        t_rw_irq();
        t_dma();
        t_reset();
        results();
    end
endmodule // test_quad_uart_irq_ready_status
bind qirq_top qirq_top_asserts #(.NUM_CHAN(NUM_CHAN)) chk_i (.clk, .resetn, .bus_strobe_select,
    .channel_d_select_n, .irq_output_override, .fifo_status_select_n, .chan_irq_pending,
    .irq_output_enable_bit, .tx_dma_enable, .rx_dma_enable, .tx_space_ready, .rx_data_ready,
    .channel_a_irq, .channel_a_irq_oe, .channel_b_irq, .channel_b_irq_oe, .channel_c_irq_oe,
    .channel_d_irq_oe, .channel_d_enabled, .chan_tx_ready_n, .chan_rx_ready_n,
    .combined_tx_ready_n, .combined_rx_ready_n, .data_out, .data_out_oe);
`default_nettype wire
